// ### dv/pcr_host_model.sv
`include "pcr_map.svh"
`default_nettype none
module pcr_host_model (
    input wire logic clk_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic cmd_page_o,
    output logic [15:0] cmd_wdata_o,
    input wire logic [15:0] cmd_rdata_i,
    input wire logic cmd_ack_i,
    input wire logic cmd_error_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_page_o = 1'b0;
        cmd_wdata_o = 16'h5a5a;
    end
    task automatic xfer(input logic wr, input logic [7:0] code, input logic pg,
            input logic [15:0] wd, output logic [15:0] rd, output logic ak, output logic er);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= wr;
        cmd_code_o <= code;
        cmd_page_o <= pg;
        // Reserved config bits always sent as zero; other codes, reset included, send wd as given
        cmd_wdata_o <= (code == `PCR_CMD_CONFIG) ? (wd & 16'h0077) : wd;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        // Stale data is not left on the bus
        cmd_wdata_o <= ~cmd_wdata_o;
        // Answer is registered: take it one edge after the edge that samples the command
        @(posedge clk_i);
        rd = cmd_rdata_i;
        ak = cmd_ack_i;
        er = cmd_error_i;
    endtask
endmodule // pcr_host_model
`default_nettype wire

// ### dv/pcr_regs_assertions.sv
`include "pcr_map.svh"
`default_nettype none
module pcr_regs_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_page_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic cmd_error_o,
    input wire logic [1:0] ch_state0_i,
    input wire logic device_off_i,
    input wire logic soft_reset_o,
    input wire logic busy_fault_o,
    input wire logic [1:0] ilim_high_o,
    input wire logic [1:0] cond_mode0_o,
    input wire logic [15:0] freq_word_o,
    input wire logic [2:0] phase_sel_o,
    input wire logic share_clk_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire wr = cmd_valid_i && cmd_write_i;
    wire cfg_wr = wr && cmd_code_i == `PCR_CMD_CONFIG;
    wire bad_f = wr && cmd_code_i == `PCR_CMD_FREQ && !(cmd_wdata_i inside {`PCR_FREQ_EXT,
        `PCR_FREQ_250, `PCR_FREQ_350, `PCR_FREQ_425, `PCR_FREQ_500, `PCR_FREQ_575,
        `PCR_FREQ_650, `PCR_FREQ_750, `PCR_FREQ_1000});
    property p_rst_pulse;
        wr && cmd_code_i == `PCR_CMD_RESET |=> soft_reset_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset not taken");
    property p_rst_dflt;
        soft_reset_o |=> freq_word_o == `PCR_FREQ_RST && phase_sel_o == 3'h0
            && !busy_fault_o && ilim_high_o == 2'b11;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt) else $error("defaults lost");
    property p_ilim;
        wr && cmd_code_i == `PCR_CMD_MODE |=>
            ilim_high_o[$past(cmd_page_i)] == $past(cmd_wdata_i[7]);
    endproperty
    a_ilim: assert property (p_ilim) else $error("ilim range wrong");
    property p_ramp;
        (ch_state0_i == pcr_pkg::PCR_CH_RAMP_ON)[*5] |-> cond_mode0_o == 2'b00;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp not discontinuous");
    sequence s_run_cfg;
        (!device_off_i)[*5] ##0 cfg_wr;
    endsequence
    property p_busy;
        s_run_cfg |=> cmd_error_o && busy_fault_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy fault missing");
    property p_keep;
        s_run_cfg |=> $stable(phase_sel_o);
    endproperty
    a_keep: assert property (p_keep) else $error("config changed while running");
    property p_badf;
        bad_f |=> cmd_error_o && $stable(freq_word_o);
    endproperty
    a_badf: assert property (p_badf) else $error("illegal freq taken");
    property p_oe;
        $fell(rst_i) |-> share_clk_oe_o;
    endproperty
    a_oe: assert property (p_oe) else $error("share clock released early");
    c_cfg: cover property (s_run_cfg);
    c_badf: cover property (bad_f);
    c_rst: cover property (soft_reset_o);
endmodule // pcr_regs_checker
bind pcr_regs pcr_regs_checker pcr_regs_checker_inst (.clk_i, .rst_i, .cmd_valid_i,
    .cmd_write_i, .cmd_code_i, .cmd_page_i, .cmd_wdata_i, .cmd_error_o, .ch_state0_i,
    .device_off_i, .soft_reset_o, .busy_fault_o, .ilim_high_o, .cond_mode0_o,
    .freq_word_o, .phase_sel_o, .share_clk_oe_o);
`default_nettype wire

// ### dv/tb.sv
`include "pcr_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] st0 = 2'b00;
    logic [1:0] st1 = 2'b00;
    logic off = 1'b1;
    logic von = 1'b0;
    logic voff = 1'b0;
    logic [15:0] tg = 16'h0100;
    logic [15:0] ms = 16'h0080;
    logic v, w, p, ak, er, srst, busy, r0, r1, oe, a, e, sc;
    logic [7:0] c;
    logic [15:0] d, rdat, tr0, tr1, fw, r;
    logic [1:0] ilim, cm0, cm1;
    logic [2:0] ph;
    int failures = 0;
    int comparisons = 0;
    logic [15:0] fl [9] = '{`PCR_FREQ_EXT, `PCR_FREQ_250, `PCR_FREQ_350, `PCR_FREQ_425,
        `PCR_FREQ_500, `PCR_FREQ_575, `PCR_FREQ_650, `PCR_FREQ_750, `PCR_FREQ_1000};
    pcr_host_model pcr_host_model_inst (
        .clk_i(clk), .cmd_valid_o(v), .cmd_write_o(w), .cmd_code_o(c), .cmd_page_o(p),
        .cmd_wdata_o(d), .cmd_rdata_i(rdat), .cmd_ack_i(ak), .cmd_error_i(er));
    pcr_regs pcr_regs_inst (
        .clk_i(clk), .rst_i(rst), .cmd_valid_i(v), .cmd_write_i(w), .cmd_code_i(c),
        .cmd_page_i(p), .cmd_wdata_i(d), .cmd_rdata_o(rdat), .cmd_ack_o(ak), .cmd_error_o(er),
        .ch_state0_i(st0), .ch_state1_i(st1), .device_off_i(off), .vin_above_on_i(von),
        .vin_below_off_i(voff), .target0_i(tg), .target1_i(tg), .measured0_i(ms),
        .measured1_i(ms), .soft_reset_o(srst), .busy_fault_o(busy), .ilim_high_o(ilim),
        .cond_mode0_o(cm0), .cond_mode1_o(cm1), .dac_trim0_o(tr0), .dac_trim1_o(tr1),
        .range0_low_o(r0), .range1_low_o(r1), .phase_sel_o(ph), .freq_word_o(fw),
        .share_clk_o(sc), .share_clk_oe_o(oe));
    task automatic give_verdict();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic x(input logic wr, input logic [7:0] code, input logic pg,
            input logic [15:0] wd);
        pcr_host_model_inst.xfer(wr, code, pg, wd, r, a, e);
        chk(a, 1'b1);
    endtask
    task automatic t_dflt();
        chk(oe, 1'b1);
        chk(sc, 1'b0);
        x(0, `PCR_CMD_MODE, 1, 0);
        chk(r, `PCR_MODE_RST);
        x(0, `PCR_CMD_CONFIG, 0, 0);
        chk(r, `PCR_CONFIG_RST);
        x(0, `PCR_CMD_FREQ, 0, 0);
        chk(r, `PCR_FREQ_RST);
    endtask
    task automatic t_share();
        von <= 1'b1;
        wt(5);
        chk(oe, 1'b0);
        von <= 1'b0;
        voff <= 1'b1;
        wt(5);
        chk(oe, 1'b1);
        x(1, `PCR_CMD_CONFIG, 0, 0);
        voff <= 1'b0;
        von <= 1'b1;
        wt(5);
        von <= 1'b0;
        voff <= 1'b1;
        wt(5);
        chk(oe, 1'b0);
    endtask
    task automatic t_mode();
        x(1, `PCR_CMD_MODE, 0, 16'h0001);
        chk(ilim, 2'b10);
        st0 <= pcr_pkg::PCR_CH_ON;
        for (int m = 0; m < 3; m++) begin
            x(1, `PCR_CMD_MODE, 0, m);
            wt(5);
            chk(cm0, m);
        end
        st0 <= pcr_pkg::PCR_CH_RAMP_ON;
        wt(6);
        chk(cm0, 2'b00);
        x(1, `PCR_CMD_MODE, 1, 16'h0040);
        chk(ilim, 2'b00);
        wt(600);
        chk(tr1, 16'h0000);
        st1 <= pcr_pkg::PCR_CH_ON;
        wt(800);
        // Sync latency is a few cycles, far below one trim step
        chk(tr1, 16'(800 / (`PCR_SERVO_DIV + 1)));
        chk(tr0, 16'h0000);
        x(1, `PCR_CMD_MODE, 1, 16'h0041);
        wt(5);
        chk(cm1, 2'b01);
        chk(cm0, 2'b00);
    endtask
    task automatic t_cfg();
        for (int k = 0; k < 7; k++) begin
            x(1, `PCR_CMD_CONFIG, 0, 16'h0060 | k);
            chk(ph, k);
        end
        chk({r0, r1}, 2'b11);
        x(0, `PCR_CMD_CONFIG, 0, 0);
        chk(r, 16'h0066);
        x(1, `PCR_CMD_CONFIG, 0, 16'h0040);
        chk({r0, r1}, 2'b10);
        for (int i = 0; i < 9; i++) begin
            x(1, `PCR_CMD_FREQ, 0, fl[i]);
            chk(fw, fl[i]);
        end
        x(1, `PCR_CMD_FREQ, 0, 16'h1234);
        chk(e, 1'b1);
        chk(fw, `PCR_FREQ_1000);
    endtask
    task automatic t_busy();
        off <= 1'b0;
        wt(5);
        x(1, `PCR_CMD_CONFIG, 0, 16'h0003);
        chk({e, busy}, 2'b11);
        chk(ph, 3'h0);
        x(1, `PCR_CMD_FREQ, 0, `PCR_FREQ_500);
        chk(fw, `PCR_FREQ_1000);
        off <= 1'b1;
        x(1, `PCR_CMD_RESET, 0, 0);
        chk(srst, 1'b1);
        wt(2);
        chk(busy, 1'b0);
        x(0, `PCR_CMD_MODE, 0, 0);
        chk(r, `PCR_MODE_RST);
        x(0, `PCR_CMD_RESET, 0, 0);
        chk(e, 1'b1);
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400us;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_dflt();
        t_share();
        t_mode();
        t_cfg();
        t_busy();
        give_verdict();
    end
endmodule // tb
`default_nettype wire

// ### logic/pcr_regs.sv
`include "pcr_map.svh"
`default_nettype none
// How it works
// - Reset command restores defaults; share clock state kept
// - Code fd, send byte, unpaged reset
// - Paged mode byte at d4, default c2
// - Mode bit 7 picks current-limit range
// - Mode bits 1:0 pick conduction mode
// - Ramping on forces discontinuous mode
// - Bit 6 servo, never off or ramping
// - Servo steps DAC toward set point
// - Unpaged config byte at f5, default 10
// - Config writes accepted only when off
// - Running config write discarded, busy fault
// - Config bit 6 channel 0 range
// - Config bit 5 channel 1 range
// - Bit 4 set: clock tracks input thresholds
// - Bit 4 clear: low only at power-up
// - Config bits 2:0 choose phase pair
// - Frequency word at 33, default fabc
// - Only listed frequency encodings accepted
module pcr_regs #(
    parameter int VW = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_page_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] cmd_rdata_o,
    output logic cmd_ack_o,
    output logic cmd_error_o,
    input wire logic [1:0] ch_state0_i,
    input wire logic [1:0] ch_state1_i,
    input wire logic device_off_i,
    input wire logic vin_above_on_i,
    input wire logic vin_below_off_i,
    input wire logic [VW-1:0] target0_i,
    input wire logic [VW-1:0] target1_i,
    input wire logic [VW-1:0] measured0_i,
    input wire logic [VW-1:0] measured1_i,
    output logic soft_reset_o,
    output logic busy_fault_o,
    output logic [1:0] ilim_high_o,
    output logic [1:0] cond_mode0_o,
    output logic [1:0] cond_mode1_o,
    output logic [VW-1:0] dac_trim0_o,
    output logic [VW-1:0] dac_trim1_o,
    output logic range0_low_o,
    output logic range1_low_o,
    output logic [2:0] phase_sel_o,
    output logic [15:0] freq_word_o,
    output logic share_clk_o,
    output logic share_clk_oe_o
);
    logic [7:0] mode_reg [2];
    logic [7:0] cfg_reg;
    logic [15:0] freq_reg;
    logic [1:0] st_sync0 [2];
    logic [1:0] st_sync1 [2];
    logic [2:0] off_sync;
    logic [1:0] von_sync;
    logic [1:0] voff_sync;
    logic busy;
    pcr_pkg::pcr_shc_t shc_state;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic srst;

    // Pins are asynchronous to this clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_sync0[0] <= 2'h0;
            st_sync0[1] <= 2'h0;
            st_sync1[0] <= 2'h0;
            st_sync1[1] <= 2'h0;
            off_sync <= 3'h7;
            von_sync <= 2'h0;
            voff_sync <= 2'h0;
        end else begin
            st_sync0[0] <= ch_state0_i;
            st_sync1[0] <= st_sync0[0];
            st_sync0[1] <= ch_state1_i;
            st_sync1[1] <= st_sync0[1];
            off_sync <= {off_sync[1], off_sync[0], device_off_i};
            von_sync <= {von_sync[0], vin_above_on_i};
            voff_sync <= {voff_sync[0], vin_below_off_i};
        end
    end

    wire is_off = off_sync[2];
    wire vin_ok = von_sync[1];
    wire vin_low = voff_sync[1];
    wire do_write = cmd_valid_i && cmd_write_i;
    wire hit_reset = cmd_code_i == `PCR_CMD_RESET;
    wire hit_mode = cmd_code_i == `PCR_CMD_MODE;
    wire hit_cfg = cmd_code_i == `PCR_CMD_CONFIG;
    wire hit_freq = cmd_code_i == `PCR_CMD_FREQ;
    wire freq_legal = (cmd_wdata_i == `PCR_FREQ_EXT) || (cmd_wdata_i == `PCR_FREQ_250)
        || (cmd_wdata_i == `PCR_FREQ_350) || (cmd_wdata_i == `PCR_FREQ_425)
        || (cmd_wdata_i == `PCR_FREQ_500) || (cmd_wdata_i == `PCR_FREQ_575)
        || (cmd_wdata_i == `PCR_FREQ_650) || (cmd_wdata_i == `PCR_FREQ_750)
        || (cmd_wdata_i == `PCR_FREQ_1000);
    wire wr_mode = do_write && hit_mode;
    wire wr_cfg_ok = do_write && hit_cfg && is_off;
    wire wr_cfg_busy = do_write && hit_cfg && !is_off;
    wire wr_freq_ok = do_write && hit_freq && is_off && freq_legal;
    wire wr_freq_busy = do_write && hit_freq && !is_off;
    wire wr_freq_bad = do_write && hit_freq && is_off && !freq_legal;
    wire rd_reset = cmd_valid_i && !cmd_write_i && hit_reset;
    wire unmapped = cmd_valid_i && !(hit_reset || hit_mode || hit_cfg || hit_freq);
    wire [7:0] mode_sel = mode_reg[cmd_page_i];
    wire [15:0] next_rdata = hit_mode ? {8'h00, mode_sel}
        : hit_cfg ? {8'h00, cfg_reg}
        : hit_freq ? freq_reg : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            mode_reg[0] <= `PCR_MODE_RST;
            mode_reg[1] <= `PCR_MODE_RST;
            cfg_reg <= `PCR_CONFIG_RST;
            freq_reg <= `PCR_FREQ_RST;
        end else begin
            if (wr_mode) begin
                mode_reg[cmd_page_i] <= cmd_wdata_i[7:0] & `PCR_MODE_WMASK;
            end
            if (wr_cfg_ok) begin
                cfg_reg <= cmd_wdata_i[7:0] & `PCR_CFG_WMASK;
            end
            if (wr_freq_ok) begin
                freq_reg <= cmd_wdata_i;
            end
        end
    end

    // Busy fault stays up until a device reset
    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            busy <= 1'b0;
        end else if (wr_cfg_busy || wr_freq_busy) begin
            busy <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst <= 1'b0;
        end else begin
            srst <= do_write && hit_reset;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            ack <= cmd_valid_i;
            err <= unmapped || rd_reset || wr_cfg_busy || wr_freq_busy || wr_freq_bad;
            rdata <= (cmd_valid_i && !cmd_write_i) ? next_rdata : 16'h0000;
        end
    end

    // Share clock: hold low until input first good
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shc_state <= pcr_pkg::PCR_SHC_HOLD;
        end else begin
            case (shc_state)
                pcr_pkg::PCR_SHC_HOLD: begin
                    if (vin_ok) begin
                        shc_state <= pcr_pkg::PCR_SHC_RELEASED;
                    end
                end
                pcr_pkg::PCR_SHC_RELEASED: begin
                    if (cfg_reg[`PCR_CFG_SHCLK_BIT] && vin_low) begin
                        shc_state <= pcr_pkg::PCR_SHC_HOLD;
                    end
                end
                default: shc_state <= pcr_pkg::PCR_SHC_HOLD;
            endcase
        end
    end

    genvar g;
    for (g = 0; g < 2; g++) begin : g_ch
        wire [1:0] st = st_sync1[g];
        wire ramp_on = st == pcr_pkg::PCR_CH_RAMP_ON;
        wire servo_en = mode_reg[g][`PCR_MODE_SERVO_BIT]
            && (st == pcr_pkg::PCR_CH_ON);
        wire [1:0] cmode = ramp_on ? pcr_pkg::PCR_COND_DISC : mode_reg[g][1:0];
        logic [1:0] cmode_q;
        wire [VW-1:0] trim;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cmode_q <= 2'h0;
            end else begin
                cmode_q <= cmode;
            end
        end
        if (g == 0) begin : g0
            assign cond_mode0_o = cmode_q;
            assign dac_trim0_o = trim;
        end else begin : g1
            assign cond_mode1_o = cmode_q;
            assign dac_trim1_o = trim;
        end
        assign ilim_high_o[g] = mode_reg[g][`PCR_MODE_ILIM_BIT];
        pcr_servo #(
            .W(VW)
        ) u_servo (
            .clk_i(clk_i),
            .rst_i(rst_i || srst),
            .enable_i(servo_en),
            .target_i(g == 0 ? target0_i : target1_i),
            .measured_i(g == 0 ? measured0_i : measured1_i),
            .dac_trim_o(trim)
        );
    end

    assign cmd_rdata_o = rdata;
    assign cmd_ack_o = ack;
    assign cmd_error_o = err;
    assign soft_reset_o = srst;
    assign busy_fault_o = busy;
    assign range0_low_o = cfg_reg[`PCR_CFG_RANGE0_BIT];
    assign range1_low_o = cfg_reg[`PCR_CFG_RANGE1_BIT];
    assign phase_sel_o = cfg_reg[2:0];
    assign freq_word_o = freq_reg;
    // Line is open drain: drive low only
    assign share_clk_o = 1'b0;
    assign share_clk_oe_o = shc_state == pcr_pkg::PCR_SHC_HOLD;
endmodule // pcr_regs
`default_nettype wire

// ### logic/pcr_servo.sv
`include "pcr_map.svh"
`default_nettype none
// Slow set-point trim for one channel
module pcr_servo #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [W-1:0] target_i,
    input wire logic [W-1:0] measured_i,
    output logic [W-1:0] dac_trim_o
);
    logic [15:0] tick_cnt;
    logic [W-1:0] trim;
    wire tick = (tick_cnt == `PCR_SERVO_DIV);
    wire below = measured_i < target_i;
    wire above = measured_i > target_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end
    // Trim is held, not cleared, when servo stops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim <= '0;
        end else if (enable_i && tick && below) begin
            trim <= trim + W'(1);
        end else if (enable_i && tick && above) begin
            trim <= trim - W'(1);
        end
    end
    assign dac_trim_o = trim;
endmodule // pcr_servo
`default_nettype wire

// ### shared/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH
`define PCR_CMD_RESET 8'hfd
`define PCR_CMD_MODE 8'hd4
`define PCR_CMD_CONFIG 8'hf5
`define PCR_CMD_FREQ 8'h33
`define PCR_MODE_RST 8'hc2
`define PCR_CONFIG_RST 8'h10
`define PCR_FREQ_RST 16'hfabc
`define PCR_MODE_ILIM_BIT 7
`define PCR_MODE_SERVO_BIT 6
`define PCR_MODE_WMASK 8'hc3
`define PCR_CFG_RANGE0_BIT 6
`define PCR_CFG_RANGE1_BIT 5
`define PCR_CFG_SHCLK_BIT 4
`define PCR_CFG_WMASK 8'h77
`define PCR_FREQ_EXT 16'h0000
`define PCR_FREQ_250 16'hf3e8
`define PCR_FREQ_350 16'hfabc
`define PCR_FREQ_425 16'hfb52
`define PCR_FREQ_500 16'hfbe8
`define PCR_FREQ_575 16'h023f
`define PCR_FREQ_650 16'h028a
`define PCR_FREQ_750 16'h02ee
`define PCR_FREQ_1000 16'h03e8
`define PCR_SERVO_DIV 16'h00ff
`endif

// ### shared/pcr_pkg.sv
`default_nettype none
package pcr_pkg;
    typedef enum logic [1:0] {
        PCR_COND_DISC = 2'b00,
        PCR_COND_BURST = 2'b01,
        PCR_COND_FCCM = 2'b10
    } pcr_cond_t;
    typedef enum logic [1:0] {
        PCR_CH_OFF = 2'b00,
        PCR_CH_RAMP_ON = 2'b01,
        PCR_CH_ON = 2'b10,
        PCR_CH_RAMP_OFF = 2'b11
    } pcr_chstate_t;
    typedef enum logic [1:0] {
        PCR_SHC_HOLD = 2'b00,
        PCR_SHC_RELEASED = 2'b01
    } pcr_shc_t;
endpackage
`default_nettype wire
